// file: shared/ltx_pkg.sv
// Shared constants, types and helpers of the three-lane display link serializer.
package ltx_pkg;

  // System clock period; every time below is turned into cycles of this clock.
  localparam int CLK_PERIOD_NS = 5;

  // Parallel word layout: colour in the low bits, then the three control bits.
  localparam int WORD_W = 21;
  localparam int COLOR_W = 18;
  localparam int LINE_SYNC_BIT = 18;
  localparam int FRAME_SYNC_BIT = 19;
  localparam int VALID_BIT = 20;

  // Serial frame geometry: seven bits per lane, three data lanes and one clock lane.
  localparam int BITS_PER_LANE = 7;
  localparam int NUM_DATA_LANES = 3;
  localparam int NUM_LANES = 4;
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h6;

  // Clock lane pattern, bit 0 sent first: high, high, low, low, low, high, high.
  localparam logic [BITS_PER_LANE-1:0] CLK_PATTERN = 7'h63;

  // Counter width used for period measurement and timeouts.
  localparam int CNT_W = 16;

  // Least power-down pulse that is recognised; a least time rounds up.
  localparam int PD_MIN_NS = 1000;
  localparam int PD_CYCLES = (PD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Time without a pixel clock edge after which the clock counts as missing.
  localparam int MISS_TIME_NS = 400;
  localparam int MISS_CYCLES = MISS_TIME_NS / CLK_PERIOD_NS;

  // Top-level link state.
  typedef enum logic [2:0] {
    LTX_ST_PDOWN = 3'h1,
    LTX_ST_NOCLK = 3'h2,
    LTX_ST_RUN = 3'h4
  } ltx_state_t;

  // Drive mode of one output lane.
  typedef enum logic [2:0] {
    LTX_LANE_HIZ = 3'h1,
    LTX_LANE_LOW = 3'h2,
    LTX_LANE_SEND = 3'h4
  } ltx_mode_t;

  // One differential output pair with its active-low output enable.
  typedef struct packed {
    logic p;
    logic n;
    logic oe_n;
  } ltx_pin_t;

  // Maps the link state onto the drive mode of every lane.
  function automatic ltx_mode_t ltx_mode_of(input ltx_state_t st);
    ltx_mode_t m;
    m = LTX_LANE_HIZ;
    unique case (st)
      LTX_ST_PDOWN: m = LTX_LANE_HIZ;
      LTX_ST_NOCLK: m = LTX_LANE_LOW;
      LTX_ST_RUN: m = LTX_LANE_SEND;
    endcase
    return m;
  endfunction

  // Seven-bit slice of the word carried by a data lane, or the clock pattern.
  function automatic logic [BITS_PER_LANE-1:0] ltx_lane_bits(
      input logic [WORD_W-1:0] word, input int lane);
    logic [BITS_PER_LANE-1:0] b;
    b = CLK_PATTERN;
    if (lane < NUM_DATA_LANES) begin
      b = word[lane*BITS_PER_LANE +: BITS_PER_LANE];
    end
    return b;
  endfunction

endpackage

// file: hdl/ltx_sync.sv
// Two-flop synchroniser for single-bit levels entering the system clock domain.
module ltx_sync import ltx_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ltx_sync_t;

  ltx_sync_t s_r;
  ltx_sync_t s_nxt;

  // The first stage feeds only the second stage, never any logic.
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = d;
    s_nxt.stable = s_r.meta;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stable;

endmodule

// file: hdl/ltx_lane.sv
// One serial output lane: drives a differential pair from the selected frame bit.
module ltx_lane import ltx_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [BITS_PER_LANE-1:0] bits,
  input wire logic [IDX_W-1:0] idx,
  input wire ltx_mode_t mode,
  output ltx_pin_t pin
);

  ltx_pin_t s_r;
  ltx_pin_t s_nxt;

  // A pulled-low pair still drives, n high; high impedance releases both legs.
  always_comb begin
    s_nxt = s_r;
    unique case (mode)
      LTX_LANE_HIZ: s_nxt = '{p: 1'b0, n: 1'b0, oe_n: 1'b1};
      LTX_LANE_LOW: s_nxt = '{p: 1'b0, n: 1'b1, oe_n: 1'b0};
      LTX_LANE_SEND: s_nxt = '{p: bits[idx], n: ~bits[idx], oe_n: 1'b0};
    endcase
  end

  // The pair comes up released, so nothing is driven before the link is judged.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{p: 1'b0, n: 1'b0, oe_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin = s_r;

endmodule

// file: hdl/ltx_serializer.sv
// Top of the display link serializer: capture, clock crossing, bit timing and lane control.
module ltx_serializer import ltx_pkg::*; #(
  parameter int PD_CNT = PD_CYCLES,
  parameter int MISS_CNT = MISS_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pixel_clock_in,
  input wire logic [COLOR_W-1:0] parallel_word_in,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_valid_flag,
  input wire logic power_down_n,
  output ltx_pin_t [NUM_DATA_LANES-1:0] data_lanes,
  output ltx_pin_t clock_lane
);

  localparam logic [CNT_W-1:0] PD_LAST = CNT_W'(PD_CNT - 1);
  localparam logic [CNT_W-1:0] MISS_LIMIT = CNT_W'(MISS_CNT);
  localparam logic [CNT_W:0] STEP = (CNT_W + 1)'(BITS_PER_LANE);

  // Pixel-domain state: two word slots written in turn and the slot pointer.
  typedef struct packed {
    logic [1:0][WORD_W-1:0] bank;
    logic wr_sel;
  } ltx_pix_t;

  // System-domain state.
  typedef struct packed {
    ltx_state_t state;
    logic sel_seen;
    logic [WORD_W-1:0] frame;
    logic [IDX_W-1:0] idx;
    logic [CNT_W-1:0] acc;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] since;
    logic [CNT_W-1:0] pd_cnt;
    logic pd_active;
  } ltx_sys_t;

  ltx_pix_t p_r;
  ltx_pix_t p_nxt;
  ltx_sys_t s_r;
  ltx_sys_t s_nxt;
  logic [WORD_W-1:0] word_in;
  logic [1:0] sync_q;
  logic sel_sync;
  logic pd_n_sync;
  logic new_frame;
  logic [CNT_W:0] acc_sum;
  ltx_mode_t lane_mode;
  ltx_pin_t [NUM_LANES-1:0] lane_pins;

  // The controller supplies colour and the three control bits in fixed positions.
  assign word_in = {pixel_valid_flag, frame_sync, line_sync, parallel_word_in};

  // Each falling edge writes the whole word into the slot the pointer names and
  // flips the pointer; the slot just written then stays still for two periods,
  // which gives the system domain time to pick it up.
  always_comb begin
    p_nxt = p_r;
    p_nxt.bank[p_r.wr_sel] = word_in;
    p_nxt.wr_sel = ~p_r.wr_sel;
  end

  // The pixel clock may stop at any time, so this domain holds nothing that must end.
  always_ff @(negedge pixel_clock_in or negedge reset_n) begin
    if (!reset_n) begin
      p_r <= '0;
    end else begin
      p_r <= p_nxt;
    end
  end

  // The pointer and the power-down pin are levels from outside this domain.
  ltx_sync #(
    .WIDTH(2)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .d({p_r.wr_sel, power_down_n}),
    .q(sync_q)
  );

  assign sel_sync = sync_q[1];
  assign pd_n_sync = sync_q[0];
  assign new_frame = sel_sync != s_r.sel_seen;
  assign acc_sum = {1'b0, s_r.acc} + STEP;

  // System-domain next state. The bit clock is a fractional step: every cycle adds
  // seven to the accumulator and a bit ends each time it passes the measured period,
  // so seven bits fill one pixel period whatever its length. The trade-off is that
  // bit edges fall on system clock edges, so jitter is one system clock.
  always_comb begin
    s_nxt = s_r;
    s_nxt.sel_seen = sel_sync;
    // Time since the last pixel edge, saturating at the missing-clock limit.
    if (new_frame) begin
      s_nxt.since = '0;
    end else if (s_r.since < MISS_LIMIT) begin
      s_nxt.since = s_r.since + 1'b1;
    end
    // A power-down level is taken only after it has held for the whole least pulse.
    if (~pd_n_sync != s_r.pd_active) begin
      if (s_r.pd_cnt == PD_LAST) begin
        s_nxt.pd_active = ~pd_n_sync;
        s_nxt.pd_cnt = '0;
      end else begin
        s_nxt.pd_cnt = s_r.pd_cnt + 1'b1;
      end
    end else begin
      s_nxt.pd_cnt = '0;
    end
    // Frame load and bit stepping.
    if (new_frame) begin
      s_nxt.frame = p_r.bank[~sel_sync];
      s_nxt.idx = IDX_FIRST;
      s_nxt.acc = '0;
      s_nxt.period = s_r.since + 1'b1;
    end else if (s_r.idx != IDX_LAST) begin
      if (acc_sum >= {1'b0, s_r.period}) begin
        s_nxt.acc = CNT_W'(acc_sum - {1'b0, s_r.period});
        s_nxt.idx = s_r.idx + 1'b1;
      end else begin
        s_nxt.acc = CNT_W'(acc_sum);
      end
    end
    // Link state: power-down first, then any new frame runs, then missing clock.
    // A fresh edge proves the clock is back, so it beats a stale missing-clock count.
    if (s_r.pd_active) begin
      s_nxt.state = LTX_ST_PDOWN;
    end else if (new_frame) begin
      s_nxt.state = LTX_ST_RUN;
    end else if (s_r.since >= MISS_LIMIT) begin
      s_nxt.state = LTX_ST_NOCLK;
    end
  end

  // Reset starts as if the clock were missing, so the link needs no sequencing.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{state: LTX_ST_NOCLK, sel_seen: 1'b0, frame: '0, idx: IDX_LAST,
               acc: '0, period: MISS_LIMIT, since: MISS_LIMIT, pd_cnt: '0,
               pd_active: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lane_mode = ltx_mode_of(s_r.state);

  // Three data lanes carry the word slices and the last lane the clock pattern.
  for (genvar ln = 0; ln < NUM_LANES; ln++) begin : g_lane
    ltx_lane u_lane (
      .clock(clock),
      .reset_n(reset_n),
      .bits(ltx_lane_bits(s_r.frame, ln)),
      .idx(s_r.idx),
      .mode(lane_mode),
      .pin(lane_pins[ln])
    );
  end

  assign data_lanes = lane_pins[NUM_DATA_LANES-1:0];
  assign clock_lane = lane_pins[NUM_LANES-1];

  // Named steps of a frame: a pixel edge is seen, then the frame starts at bit 0.
  sequence seq_edge_seen;
    new_frame && !s_r.pd_active;
  endsequence

  sequence seq_frame_start;
    s_r.idx == IDX_FIRST && s_r.acc == '0;
  endsequence

  AST_FRAME_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
    new_frame |=> s_r.frame == $past(p_r.bank[~sel_sync]))
    else $error("Captured word was not loaded at the frame start.");

  AST_FRAME_START: assert property (@(posedge clock) disable iff (!reset_n)
    seq_edge_seen |=> seq_frame_start ##1 (s_r.state == LTX_ST_RUN || s_r.pd_active))
    else $error("Frame did not restart at bit zero in run state.");

  AST_IDX_RANGE: assert property (@(posedge clock) disable iff (!reset_n)
    s_r.idx <= IDX_LAST)
    else $error("Bit index went past the seventh bit.");

  AST_IDX_STEP: assert property (@(posedge clock) disable iff (!reset_n)
    !$past(new_frame) && $changed(s_r.idx) |-> s_r.idx == $past(s_r.idx) + 1'b1)
    else $error("Bit index moved other than by one.");

  AST_PERIOD: assert property (@(posedge clock) disable iff (!reset_n)
    new_frame |=> s_r.period == $past(s_r.since) + 1'b1)
    else $error("Pixel period was not re-measured at the frame start.");

  AST_CLK_LANE: assert property (@(posedge clock) disable iff (!reset_n)
    s_r.state == LTX_ST_RUN |=> clock_lane.p == CLK_PATTERN[$past(s_r.idx)]
                                && !clock_lane.oe_n)
    else $error("Clock lane does not follow its pattern.");

  AST_DATA_LANE: assert property (@(posedge clock) disable iff (!reset_n)
    s_r.state == LTX_ST_RUN |=>
      data_lanes[2].p == $past(s_r.frame[2*BITS_PER_LANE + s_r.idx])
      && data_lanes[0].n == !$past(s_r.frame[s_r.idx]))
    else $error("Data lane bit does not match the captured slice.");

  AST_NOCLK_LOW: assert property (@(posedge clock) disable iff (!reset_n)
    !s_r.pd_active && !new_frame && s_r.since >= MISS_LIMIT |=> ##1
      (!data_lanes[1].p && data_lanes[1].n && !data_lanes[1].oe_n && !clock_lane.p))
    else $error("Pairs not pulled low with the pixel clock missing.");

  AST_PDOWN_HIZ: assert property (@(posedge clock) disable iff (!reset_n)
    s_r.pd_active |=> ##1 (clock_lane.oe_n && data_lanes[0].oe_n && data_lanes[2].oe_n))
    else $error("Pairs still driven in power-down.");

  AST_PD_TAKEN: assert property (@(posedge clock) disable iff (!reset_n)
    (~pd_n_sync != s_r.pd_active) && s_r.pd_cnt == PD_LAST |=> $changed(s_r.pd_active))
    else $error("Held power-down level was not taken.");

  AST_PIX_FLIP: assert property (@(negedge pixel_clock_in) disable iff (!reset_n)
    1'b1 |=> p_r.wr_sel != $past(p_r.wr_sel))
    else $error("Slot pointer did not flip on a falling pixel edge.");

  // Further checks on lane drive, link state and capture.
  sequence seq_run_seen;
    s_r.state == LTX_ST_RUN;
  endsequence

  // A running middle lane sends its own slice with a true differential pair.
  AST_DATA_LANE1: assert property (@(posedge clock) disable iff (!reset_n)
    seq_run_seen |=> data_lanes[1].p == $past(s_r.frame[BITS_PER_LANE + s_r.idx])
      && data_lanes[1].n == !data_lanes[1].p && !data_lanes[1].oe_n)
    else $error("Middle data lane does not send its slice.");

  // The first lane sends colour bit zero first.
  AST_DATA_LANE0: assert property (@(posedge clock) disable iff (!reset_n)
    seq_run_seen |=> data_lanes[0].p == $past(s_r.frame[s_r.idx]))
    else $error("First data lane bit does not match the captured slice.");

  // The clock lane legs stay complementary while running.
  AST_CLK_LANE_N: assert property (@(posedge clock) disable iff (!reset_n)
    seq_run_seen |=> clock_lane.n == !clock_lane.p)
    else $error("Clock lane legs are not complementary.");

  // In power-down both legs are released, not just the enable.
  AST_HIZ_LEGS: assert property (@(posedge clock) disable iff (!reset_n)
    s_r.state == LTX_ST_PDOWN |=> !clock_lane.p && !clock_lane.n && clock_lane.oe_n)
    else $error("Clock lane legs not released in power-down.");

  // A stale clock with no new edge moves the link to the pulled-low state.
  AST_NOCLK_STATE: assert property (@(posedge clock) disable iff (!reset_n)
    !s_r.pd_active && !new_frame && s_r.since >= MISS_LIMIT |=> s_r.state == LTX_ST_NOCLK)
    else $error("Missing clock did not select the pulled-low state.");

  // A taken power-down always wins.
  AST_PD_STATE: assert property (@(posedge clock) disable iff (!reset_n)
    s_r.pd_active |=> s_r.state == LTX_ST_PDOWN)
    else $error("Power-down was not selected.");

  // Any new frame outside power-down runs, whatever came before.
  AST_RUN_ON_EDGE: assert property (@(posedge clock) disable iff (!reset_n)
    new_frame && !s_r.pd_active |=> s_r.state == LTX_ST_RUN)
    else $error("New frame did not start the run state.");

  // Each pixel edge restarts the period measurement.
  AST_SINCE_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
    new_frame |=> s_r.since == '0)
    else $error("Period count was not cleared at a pixel edge.");

  // The filtered power-down level only moves when the pin disagrees with it.
  AST_PD_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
    (~pd_n_sync == s_r.pd_active) |=> $stable(s_r.pd_active))
    else $error("Power-down level moved without a held pin change.");

  // The last bit holds until the next frame arrives.
  AST_IDX_HOLD_LAST: assert property (@(posedge clock) disable iff (!reset_n)
    !new_frame && s_r.idx == IDX_LAST |=> s_r.idx == IDX_LAST)
    else $error("Bit index left the last bit without a new frame.");

  // The link state code is always one of the one-hot codes.
  AST_STATE_ONEHOT: assert property (@(posedge clock) disable iff (!reset_n)
    $onehot(s_r.state))
    else $error("Link state code is not one-hot.");

  // The slot written at a falling edge holds the word seen at that edge.
  AST_PIX_CAPTURE: assert property (@(negedge pixel_clock_in) disable iff (!reset_n)
    1'b1 |=> p_r.bank[$past(p_r.wr_sel)] == $past(word_in))
    else $error("Falling pixel edge did not capture the whole word.");

endmodule

// file: tb/ltx_rx_model.sv
// Panel-side receiver model that rebuilds parallel words from the serial lanes.
module ltx_rx_model import ltx_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire ltx_pin_t [NUM_DATA_LANES-1:0] data_lanes,
  input wire ltx_pin_t clock_lane,
  output logic [27:0] rx_word,
  output logic rx_stb
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] hist_r [64];
  logic [5:0] now_r;
  logic [5:0] rise_r;
  logic [5:0] per_r;
  logic [7:0] wait_r;
  logic clk_d_r;
  int ofs;

  // Lanes are recorded every cycle; a rise on the clock lane marks the start of bit 5.
  // Bits are read at their centres, scaled by the frame length just measured.
  // That way a slowly drifting pixel rate is followed too.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      now_r <= 6'h0;
      rise_r <= 6'h0;
      per_r <= 6'h20;
      wait_r <= 8'h0;
      clk_d_r <= 1'b0;
      rx_stb <= 1'b0;
      rx_word <= 28'h0;
    end else begin
      now_r <= now_r + 6'h1;
      hist_r[now_r] <= {clock_lane.p, data_lanes[2].p, data_lanes[1].p, data_lanes[0].p};
      clk_d_r <= clock_lane.p;
      rx_stb <= 1'b0;
      if (wait_r != 8'h0) begin
        wait_r <= wait_r - 8'h1;
      end
      if (clock_lane.p && !clk_d_r && !clock_lane.oe_n) begin
        per_r <= now_r - rise_r;
        rise_r <= now_r;
        wait_r <= 8'(per_r / 4 + 3);
      end else if (wait_r == 8'h1) begin
        rx_stb <= 1'b1;
        for (int k = 0; k < 7; k++) begin
          ofs = ((2 * k + 1) * per_r) / 14 - (5 * per_r) / 7;
          for (int l = 0; l < 4; l++) begin
            rx_word[7 * l + k] <= hist_r[6'(rise_r + 6'(ofs))][l];
          end
        end
      end
    end
  end
endmodule

// file: tb/ltx_serializer_tb.sv
// Self-checking testbench of the display link serializer.
module ltx_serializer_tb import ltx_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PD_T = 8;
  localparam int MISS_T = 40;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic pixel_clock_in = 1'b0;
  logic power_down_n = 1'b1;
  logic prun = 1'b0;
  real phalf = 80.0;
  logic pclk_d = 1'b0;
  int ph = 0;
  logic [WORD_W-1:0] pw = 21'h0;
  logic [WORD_W-1:0] cur_w = 21'h0;
  ltx_pin_t [NUM_DATA_LANES-1:0] data_lanes;
  ltx_pin_t clock_lane;
  logic [27:0] rx_word;
  logic rx_stb;
  logic [27:0] got[$];
  int num_errors = 0;
  int check_count = 0;
  wire [11:0] lanes = {data_lanes, clock_lane};

  ltx_serializer #(.PD_CNT(PD_T), .MISS_CNT(MISS_T)) ltx_serializer_i (
    .clock(clock), .reset_n(reset_n), .pixel_clock_in(pixel_clock_in),
    .parallel_word_in(pw[COLOR_W-1:0]), .line_sync(pw[LINE_SYNC_BIT]),
    .frame_sync(pw[FRAME_SYNC_BIT]), .pixel_valid_flag(pw[VALID_BIT]),
    .power_down_n(power_down_n), .data_lanes(data_lanes), .clock_lane(clock_lane));
  ltx_rx_model ltx_rx_model_i (.clock(clock), .reset_n(reset_n), .data_lanes(data_lanes),
    .clock_lane(clock_lane), .rx_word(rx_word), .rx_stb(rx_stb));

  // System clock at 200 MHz.
  always #2.5 clock = ~clock;

  // Pixel clock, offset so that its edges never coincide with the system clock.
  initial begin
    #1.3;
    forever #(phalf) pixel_clock_in = prun ? ~pixel_clock_in : 1'b0;
  end

  // The word is valid only around the falling edge, so a rising-edge sampler sees junk.
  always @(posedge clock) begin
    pclk_d <= pixel_clock_in;
    ph <= (pixel_clock_in && !pclk_d) ? 0 : ph + 1;
    if (ph == 8) pw <= cur_w;
    if (ph == 20) pw <= ~cur_w;
  end

  // Received frames are queued for the scenarios to inspect.
  always @(posedge clock) if (rx_stb) got.push_back(rx_word);

  task automatic cmp(input string what, input logic [27:0] exp, input logic [27:0] act);
    check_count++;
    if (act !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic send(input logic [WORD_W-1:0] w);
    @(posedge clock iff ph == 2);
    cur_w = w;
  endtask

  // Three warm-up words absorb the slow first frame, then n words are checked in order.
  task automatic stream(input logic [WORD_W-1:0] base, input int n);
    logic [WORD_W-1:0] w[$];
    int j;
    j = -1;
    for (int i = 0; i < n + 3; i++) w.push_back(base + 21'(i) * 21'h0b5a3);
    got.delete();
    foreach (w[i]) send(w[i]);
    repeat (3) send(~base);
    foreach (got[k]) if (j < 0 && got[k] === {7'h63, w[3]}) j = k;
    cmp("frame run found", 28'h1, {27'h0, 1'(j >= 0 && j + n <= got.size())});
    for (int i = 0; j >= 0 && i < n && j + i < got.size(); i++) begin
      cmp("frame", {7'h63, w[3 + i]}, got[j + i]);
    end
  endtask

  task automatic t_idle();
    repeat (3) @(posedge clock);
    cmp("idle lanes low", 28'h492, {16'h0, lanes});
  endtask

  task automatic t_missing();
    prun = 1'b0;
    // The last falling edge may come up to half a pixel period after the stop.
    repeat (MISS_T + 32) @(posedge clock);
    cmp("missing clock lanes", 28'h492, {16'h0, lanes});
    prun = 1'b1;
    stream(21'h1c0f3, 4);
  endtask

  // A pulse shorter than the filter must leave no trace at the pins.
  task automatic t_pd_short();
    logic seen;
    seen = 1'b0;
    @(posedge clock);
    power_down_n <= 1'b0;
    repeat (PD_T - 4) @(posedge clock);
    power_down_n <= 1'b1;
    repeat (PD_T + 20) begin
      @(posedge clock);
      seen = seen | clock_lane.oe_n;
    end
    cmp("short pulse", 28'h0, {27'h0, seen});
  endtask

  task automatic t_pd_long();
    power_down_n <= 1'b0;
    repeat (PD_T + 12) @(posedge clock);
    cmp("power down lanes", 28'h249, {16'h0, lanes});
    power_down_n <= 1'b1;
    repeat (PD_T + 12) @(posedge clock);
    stream(21'h05a5a, 4);
  endtask

  task automatic t_spread();
    phalf = 75.0;
    stream(21'h0f00f, 4);
    phalf = 85.0;
    stream(21'h13579, 4);
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge clock);
    cmp("reset lanes", 28'h249, {16'h0, lanes});
    reset_n <= 1'b1;
    t_idle();
    prun = 1'b1;
    stream(21'h12345, 6);
    t_missing();
    t_pd_short();
    t_pd_long();
    t_spread();
    end_of_test();
  end

  // Watchdog well beyond the expected run of some 9 us.
  initial begin
    #60us;
    num_errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
